// ==== common/upper_sfr_pkg.sv ====
// Purpose: constants, layouts and reset values of the upper special register bank
// Assumes: registers are 8 bits, one per aligned 32-bit bus word at four times the index
// Notes: slot tables list each byte register in ascending index order
package upper_sfr_pkg;
	localparam int ADDR_W = 18;
	localparam int IDX_W = 16;
	localparam int NSLOT = 33;
	localparam int SLOT_W = 6;
	localparam int NEVT = 3;

	// access abilities of one byte register
	typedef struct packed {
		logic readable;
		logic writable;
		logic bit_ok;
		logic byte_ok;
		logic word_lo;
		logic word_only;
	} attr_s;

	localparam attr_s A_WLO = 6'b110011; // low half of word-only pair
	localparam attr_s A_WHI = 6'b110001; // high half of word-only pair
	localparam attr_s A_BB = 6'b111100; // bit and byte
	localparam attr_s A_BBW = 6'b111110; // bit, byte, and word at this even index
	localparam attr_s A_BYTE = 6'b110100; // byte only
	localparam attr_s A_WO = 6'b010100; // write-only byte

	localparam logic [IDX_W-1:0] SLOT_INDEX [NSLOT] = '{
		16'hffb2, 16'hffb3, 16'hffb4, 16'hffb5, 16'hffb6, 16'hffb7, 16'hffb8, 16'hffb9,
		16'hffba, 16'hffbb, 16'hffbc, 16'hffbd, 16'hffbe, 16'hffbf, 16'hffc0, 16'hffc2,
		16'hffc4, 16'hffe0, 16'hffe1, 16'hffe2, 16'hffe3, 16'hffe4, 16'hffe5, 16'hffe6,
		16'hffe7, 16'hffe8, 16'hffe9, 16'hffea, 16'hffeb, 16'hfff0, 16'hfff4, 16'hfff8,
		16'hfffb};
	localparam logic [7:0] SLOT_RESET [NSLOT] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff,
		8'hdf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hcf, 8'h0c, 8'h10,
		8'h00};
	localparam attr_s SLOT_ATTR [NSLOT] = '{
		A_WLO, A_WHI, A_WLO, A_WHI, A_BB, A_BB, A_BB, A_BB,
		A_BB, A_BB, A_BB, A_BB, A_BB, A_BYTE, A_WO, A_BB,
		A_BB, A_BBW, A_BB, A_BBW, A_BB, A_BBW, A_BB, A_BBW,
		A_BB, A_BBW, A_BB, A_BBW, A_BB, A_BYTE, A_BYTE, A_BB,
		A_BB};

	// slots with special handling
	localparam int SLOT_CC_A = 0;
	localparam int SLOT_T1_MODE = 4;
	localparam int SLOT_LV_CTRL = 12;
	localparam int SLOT_LV_LEVEL = 13;
	localparam int SLOT_FLASH_CMD = 14;
	localparam int SLOT_FLASH_MODE = 16;
	localparam int SLOT_REQ0_LO = 17;
	localparam int SLOT_REQ1_HI = 20;
	localparam int SLOT_MASK1_HI = 24;
	localparam int SLOT_PRIO0_LO = 25;
	localparam int SLOT_MEM_SIZE = 29;
	localparam int SLOT_MEM_WAIT = 31;
	localparam int SLOT_CPU_CLK = 32;
	localparam logic [7:0] FLASH_MODE_USER = 8'h08;
	localparam logic [7:0] FLASH_MODE_ONBOARD = 8'h0c;

	// event status, clear and enable registers
	localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 16'hffd0;
	localparam logic [IDX_W-1:0] IDX_EVT_CLEAR = 16'hffd1;
	localparam logic [IDX_W-1:0] IDX_EVT_ENABLE = 16'hffd2;
	localparam int EVT_REFUSED = 0;
	localparam int EVT_UNMAPPED = 1;
	localparam int EVT_FLASH_CMD = 2;

	// access kind carried by the write strobes
	localparam logic [3:0] STRB_BYTE = 4'h1;
	localparam logic [3:0] STRB_WORD = 4'h3;
	localparam logic [3:0] STRB_BIT = 4'h4;
	localparam int BIT_VALUE_POS = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage : upper_sfr_pkg

// ==== hw/upper_sfr_regs.sv ====
// Purpose: upper special register bank (timers, low-voltage, flash, interrupt flags, memory)
// Assumes: AXI4-Lite slave; byte address = 4 x register index; access kind from wstrb
// Notes: wstrb 0001 byte, 0011 16-bit pair, 0100 single bit (bit no. wdata[2:0], value wdata[16])
//
// Contract
// - request flag bytes reset to zero; bit, byte and 16-bit pair read/write
// - mask flag bytes reset to ones, upper byte of pair one resets with bit 5 clear
// - priority flag bytes reset to ones; bit, byte and 16-bit pair access
// - second timer capture/compare registers: 16-bit access only, reset zero
// - both timers' mode, prescaler, capture and output bytes: reset zero, bit and byte
// - low-voltage registers keep a reset-source-dependent value; level select byte only
// - flash command write-only byte; flash status bit/byte read/write, reset zero
// - flash programming mode control resets by operating mode, user or on-board
// - internal memory size byte-only read/write, resets to the largest setting
// - memory wait register bit and byte read/write, reset with only bit 4 set
// - processor clock control bit and byte read/write, reset zero
module upper_sfr_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// reset straps sampled while reset is high
	input wire logic reset_by_low_volt,
	input wire logic onboard_mode,
	// write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [upper_sfr_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address and data
	input wire logic arvalid,
	output logic arready,
	input wire logic [upper_sfr_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// register contents towards the peripherals
	output logic [upper_sfr_pkg::NSLOT-1:0][7:0] sfr_bytes_ff,
	output logic flash_cmd_strobe_ff,
	output logic [7:0] flash_cmd_data_ff,
	// interrupt
	output logic irq_ff
);
	import upper_sfr_pkg::*;

	logic aw_held_ff;
	logic w_held_ff;
	logic [IDX_W-1:0] aw_idx_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [NEVT-1:0] evt_status_ff;
	logic [NEVT-1:0] evt_enable_ff;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic wr_go;
	logic nxt_aw_held;
	logic nxt_w_held;
	logic nxt_bvalid;
	logic nxt_rvalid;
	logic wr_hit;
	logic rd_hit;
	logic [SLOT_W-1:0] wr_slot;
	logic [SLOT_W-1:0] rd_slot;
	logic [IDX_W-1:0] rd_idx;
	attr_s wr_attr;
	attr_s rd_attr;
	logic kind_byte;
	logic kind_word;
	logic kind_bit;
	logic is_status;
	logic is_clear;
	logic is_enable;
	logic wr_mapped;
	logic rd_mapped;
	logic wr_ok;
	logic irq_wr_ok;
	logic wr_lo;
	logic wr_hi;
	logic wr_cmd;
	logic [7:0] hi_byte;
	logic [7:0] bit_merged;
	logic [7:0] lo_val;
	logic [NEVT-1:0] evt_set;
	logic [NEVT-1:0] evt_clr;
	logic [NEVT-1:0] nxt_status;
	logic [NEVT-1:0] nxt_enable;
	logic [31:0] rd_value;
	logic [NSLOT-1:0][7:0] nxt_sfr;
	logic [NSLOT-1:0][7:0] rst_sfr;

	// bus handshakes; address and data are taken in either order
	assign aw_fire = awvalid & awready;
	assign w_fire = wvalid & wready;
	assign ar_fire = arvalid & arready;
	assign wr_go = aw_held_ff & w_held_ff & ~bvalid;
	assign nxt_aw_held = (aw_held_ff | aw_fire) & ~wr_go;
	assign nxt_w_held = (w_held_ff | w_fire) & ~wr_go;
	assign nxt_bvalid = wr_go | (bvalid & ~bready);
	assign nxt_rvalid = ar_fire | (rvalid & ~rready);

	// channel state; readies are registered so they stand from flops
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			awready <= ~nxt_aw_held;
			wready <= ~nxt_w_held;
			arready <= ~nxt_rvalid;
			bvalid <= nxt_bvalid;
			rvalid <= nxt_rvalid;
		end
	end

	// captured write payload; no reset needed, qualified by the held flags
	always_ff @(posedge clk) begin
		if (aw_fire) begin
			aw_idx_ff <= awaddr[ADDR_W-1:2];
		end
		if (w_fire) begin
			wdata_ff <= wdata;
			wstrb_ff <= wstrb;
		end
	end

	// slot lookup for both channels; a miss leaves slot zero but hit low
	always_comb begin
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		wr_slot = '0;
		rd_slot = '0;
		for (int s = 0; s < NSLOT; s++) begin
			if (SLOT_INDEX[s] == aw_idx_ff) begin
				wr_hit = 1'b1;
				wr_slot = SLOT_W'(s);
			end
			if (SLOT_INDEX[s] == rd_idx) begin
				rd_hit = 1'b1;
				rd_slot = SLOT_W'(s);
			end
		end
	end

	// access kind and legality of the pending write
	assign rd_idx = araddr[ADDR_W-1:2];
	assign wr_attr = SLOT_ATTR[wr_slot];
	assign rd_attr = SLOT_ATTR[rd_slot];
	assign kind_byte = wstrb_ff == STRB_BYTE;
	assign kind_word = wstrb_ff == STRB_WORD;
	assign kind_bit = wstrb_ff == STRB_BIT;
	assign is_status = aw_idx_ff == IDX_EVT_STATUS;
	assign is_clear = aw_idx_ff == IDX_EVT_CLEAR;
	assign is_enable = aw_idx_ff == IDX_EVT_ENABLE;
	assign wr_mapped = wr_hit | is_status | is_clear | is_enable;
	assign rd_mapped = rd_hit | (rd_idx == IDX_EVT_STATUS) | (rd_idx == IDX_EVT_CLEAR)
		| (rd_idx == IDX_EVT_ENABLE);
	assign wr_ok = wr_hit & wr_attr.writable & ((kind_byte & wr_attr.byte_ok)
		| (kind_bit & wr_attr.bit_ok) | (kind_word & wr_attr.word_lo));
	assign irq_wr_ok = kind_byte & (is_clear | is_enable);
	assign wr_cmd = wr_go & wr_ok & (wr_slot == SLOT_W'(SLOT_FLASH_CMD));
	assign wr_lo = wr_go & wr_ok & ~wr_cmd;
	assign wr_hi = wr_lo & kind_word;
	assign hi_byte = wdata_ff[15:8];

	// single-bit write is a merge into the current byte
	always_comb begin
		bit_merged = sfr_bytes_ff[wr_slot];
		bit_merged[wdata_ff[2:0]] = wdata_ff[BIT_VALUE_POS];
	end
	assign lo_val = kind_bit ? bit_merged : wdata_ff[7:0];

	// next register contents
	// low byte even, high byte odd
	always_comb begin
		nxt_sfr = sfr_bytes_ff;
		if (wr_lo) begin
			nxt_sfr[wr_slot] = lo_val;
		end
		if (wr_hi) begin
			nxt_sfr[SLOT_W'(wr_slot + 1'b1)] = hi_byte;
		end
	end

	// reset image; straps pick the mode-dependent values
	// flash mode by operating mode
	always_comb begin
		for (int s = 0; s < NSLOT; s++) begin
			rst_sfr[s] = SLOT_RESET[s];
		end
		rst_sfr[SLOT_FLASH_MODE] = onboard_mode ? FLASH_MODE_ONBOARD : FLASH_MODE_USER;
		if (reset_by_low_volt) begin
			rst_sfr[SLOT_LV_CTRL] = sfr_bytes_ff[SLOT_LV_CTRL];
			rst_sfr[SLOT_LV_LEVEL] = sfr_bytes_ff[SLOT_LV_LEVEL];
		end
	end

	always_ff @(posedge clk) begin
		sfr_bytes_ff <= reset ? rst_sfr : nxt_sfr;
	end

	// flash command strobe, one cycle per accepted write
	always_ff @(posedge clk) begin
		if (reset) begin
			flash_cmd_strobe_ff <= 1'b0;
			flash_cmd_data_ff <= 8'h00;
		end else begin
			flash_cmd_strobe_ff <= wr_cmd;
			if (wr_cmd) begin
				flash_cmd_data_ff <= wdata_ff[7:0];
			end
		end
	end

	// events: refused access, unmapped access, flash command
	// unlisted and read-only writes
	assign evt_set[EVT_REFUSED] = wr_go & wr_mapped & ~wr_ok & ~irq_wr_ok;
	assign evt_set[EVT_UNMAPPED] = (wr_go & ~wr_mapped) | (ar_fire & ~rd_mapped);
	assign evt_set[EVT_FLASH_CMD] = wr_cmd;
	assign evt_clr = (wr_go & is_clear & kind_byte) ? wdata_ff[NEVT-1:0] : '0;
	// a new event wins over a clear in the same cycle
	assign nxt_status = (evt_status_ff & ~evt_clr) | evt_set;
	assign nxt_enable = (wr_go & is_enable & kind_byte) ? wdata_ff[NEVT-1:0] : evt_enable_ff;

	// status, enable and the level interrupt
	always_ff @(posedge clk) begin
		if (reset) begin
			evt_status_ff <= '0;
			evt_enable_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			evt_status_ff <= nxt_status;
			evt_enable_ff <= nxt_enable;
			irq_ff <= |(nxt_status & nxt_enable);
		end
	end

	// read mux; a pair's even index also returns the high byte in [15:8]
	// write-only reads zero
	always_comb begin
		rd_value = 32'h0000_0000;
		if (rd_hit && rd_attr.readable && !(rd_attr.word_only && !rd_attr.word_lo)) begin
			rd_value[7:0] = sfr_bytes_ff[rd_slot];
			if (rd_attr.word_lo) begin
				rd_value[15:8] = sfr_bytes_ff[SLOT_W'(rd_slot + 1'b1)];
			end
		end else if (rd_idx == IDX_EVT_STATUS) begin
			rd_value[NEVT-1:0] = evt_status_ff;
		end else if (rd_idx == IDX_EVT_ENABLE) begin
			rd_value[NEVT-1:0] = evt_enable_ff;
		end
	end

	// answers are always OKAY; refusals show only in the event status
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
			bresp <= RESP_OKAY;
		end else begin
			rresp <= RESP_OKAY;
			bresp <= RESP_OKAY;
			if (ar_fire) begin
				rdata <= rd_value;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// reset values and access rules of the register families
	a_reqflag_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_REQ1_HI:SLOT_REQ0_LO] == '0)
		else $error("request flags not zero after reset");
	a_reqflag_word: assert property ((wr_lo && wr_hi && wr_slot == SLOT_W'(SLOT_REQ0_LO))
		|=> sfr_bytes_ff[SLOT_REQ0_LO + 1] == $past(hi_byte))
		else $error("request flag word write lost high byte");
	a_mask_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_MASK1_HI] == SLOT_RESET[SLOT_MASK1_HI])
		else $error("mask high byte reset wrong");
	a_prio_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_PRIO0_LO] == SLOT_RESET[SLOT_PRIO0_LO])
		else $error("priority flags reset wrong");
	a_cc_word_only: assert property ((wr_go && wr_hit && wr_slot == SLOT_W'(SLOT_CC_A)
		&& !kind_word) |=> $stable(sfr_bytes_ff[SLOT_CC_A]))
		else $error("capture register took a narrow write");
	a_timer_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_T1_MODE] == SLOT_RESET[SLOT_T1_MODE])
		else $error("timer control not cleared by reset");
	a_level_no_bit: assert property ((wr_go && wr_hit && wr_slot == SLOT_W'(SLOT_LV_LEVEL)
		&& kind_bit) |=> $stable(sfr_bytes_ff[SLOT_LV_LEVEL]) && evt_status_ff[EVT_REFUSED])
		else $error("level select accepted a bit write");
	a_cmd_read_zero: assert property ((ar_fire && rd_hit
		&& rd_slot == SLOT_W'(SLOT_FLASH_CMD)) |=> rvalid && rdata == 32'h0000_0000)
		else $error("write-only register read non-zero");
	a_flash_mode_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_FLASH_MODE] == ($past(onboard_mode) ? FLASH_MODE_ONBOARD
		: FLASH_MODE_USER))
		else $error("flash mode reset value wrong");
	a_mem_size_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_MEM_SIZE] == SLOT_RESET[SLOT_MEM_SIZE])
		else $error("memory size reset value wrong");
	a_wait_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_MEM_WAIT] == SLOT_RESET[SLOT_MEM_WAIT])
		else $error("wait register reset value wrong");
	a_cpu_clk_reset: assert property ($past(reset) |->
		sfr_bytes_ff[SLOT_CPU_CLK] == SLOT_RESET[SLOT_CPU_CLK])
		else $error("clock control reset value wrong");
	// refusals, bus answers and events
	a_unmapped_zero: assert property ((ar_fire && !rd_mapped) |=>
		rvalid && rdata == 32'h0000_0000 && evt_status_ff[EVT_UNMAPPED])
		else $error("unlisted read not zero");
	a_write_answer: assert property ((aw_fire && w_fire && !bvalid) |-> ##[1:2] bvalid)
		else $error("write response late");
	a_irq_level: assert property (irq_ff == |(evt_status_ff & evt_enable_ff))
		else $error("interrupt level disagrees with status");
	a_set_wins: assert property ((evt_set != '0) |=>
		(evt_status_ff & $past(evt_set)) == $past(evt_set))
		else $error("event lost against clear");

	c_word_write: cover property (wr_hi);
	c_bit_write: cover property (wr_lo && kind_bit);
	c_irq_rise: cover property ($rose(irq_ff));
	// single bits, pulses and the event registers
	a_odd_half_zero: assert property ((ar_fire && rd_hit && rd_attr.word_only
		&& !rd_attr.word_lo) |=> rdata == 32'h0000_0000)
		else $error("odd half of a word-only pair read non-zero");
	a_cmd_pulse: assert property (flash_cmd_strobe_ff |=> !flash_cmd_strobe_ff)
		else $error("flash command strobe longer than one cycle");
	a_wait_bit: assert property ((wr_lo && kind_bit && wr_slot == SLOT_W'(SLOT_MEM_WAIT))
		|=> sfr_bytes_ff[SLOT_MEM_WAIT][$past(wdata_ff[2:0])]
		== $past(wdata_ff[BIT_VALUE_POS]))
		else $error("bit write to wait register lost");
	a_bad_kind: assert property ((wr_go && wr_hit && !kind_byte && !kind_bit && !kind_word)
		|=> $stable(sfr_bytes_ff) && evt_status_ff[EVT_REFUSED])
		else $error("unknown access kind changed a register");
	a_status_read_only: assert property ((wr_go && is_status) |=>
		evt_status_ff[EVT_REFUSED] && $stable(evt_enable_ff))
		else $error("status register accepted a write");
	a_enable_write: assert property ((wr_go && is_enable && kind_byte) |=>
		evt_enable_ff == $past(wdata_ff[NEVT-1:0]))
		else $error("enable register write lost");
	a_reset_idle: assert property ($past(reset) |->
		!bvalid && !rvalid && !irq_ff && !flash_cmd_strobe_ff)
		else $error("bus answer or pulse standing after reset");

	c_unmapped_read: cover property (ar_fire && !rd_mapped);
	c_flash_cmd: cover property (flash_cmd_strobe_ff);
endmodule : upper_sfr_regs

// ==== verif/core_master_model.sv ====
// Purpose: processor core side, issuing register reads and writes over AXI4-Lite
// Assumes: one write and one read at most under way; byte address is four times the index
// Notes: after the time-zero idle, every signal changes by non-blocking assignment just after a rising edge
module core_master_model (
	// clock
	input wire logic clk,
	// write channels
	output logic awvalid,
	input wire logic awready,
	output logic [upper_sfr_pkg::ADDR_W-1:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic arvalid,
	input wire logic arready,
	output logic [upper_sfr_pkg::ADDR_W-1:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
	end
	// write; the answer may take any number of cycles, the bench watchdog ends a hang
	// word pairs
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			// released data is scrambled so stale bytes cannot pass for a match
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
			if (bvalid && bready)
				break;
		end
		bready <= 1'b0;
	endtask : wr
	// read; data taken at the edge where rvalid is sampled high
	task automatic rd(input logic [15:0] idx, output logic [31:0] d);
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				break;
			end
		end
		rready <= 1'b0;
	endtask : rd
endmodule : core_master_model

// ==== verif/upper_sfr_register_map_tb_top.sv ====
// Purpose: self-checking bench for the upper special register bank
// Assumes: core model issues all bus traffic; straps driven here
// Notes: expected values are written out by hand, not taken from the package tables
module upper_sfr_register_map_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import upper_sfr_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic lv_src = 1'b0;
	logic onboard = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, strobe, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [7:0] cmd_data;
	logic [1:0] bresp, rresp;
	logic [NSLOT-1:0][7:0] sfr_bytes;
	int num_errors = 0;
	int num_checks = 0;
	int strobes = 0;

	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end
	// count command pulses; a held strobe would count twice
	always @(posedge clk) begin
		if (strobe === 1'b1)
			strobes <= strobes + 1;
	end
	// every answer is OKAY, refused accesses included
	always @(posedge clk) begin
		if (bvalid === 1'b1 && bready === 1'b1)
			chk({30'h0, bresp}, 32'h0, "write response");
		if (rvalid === 1'b1 && rready === 1'b1)
			chk({30'h0, rresp}, 32'h0, "read response");
	end

	core_master_model i_core (.clk(clk), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata));

	upper_sfr_regs i_dut (.clk(clk), .reset(reset), .reset_by_low_volt(lv_src),
		.onboard_mode(onboard), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sfr_bytes_ff(sfr_bytes),
		.flash_cmd_strobe_ff(strobe), .flash_cmd_data_ff(cmd_data), .irq_ff(irq));

	task automatic end_of_test;
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
			num_errors++;
		end
	endtask : chk

	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		i_core.rd(idx, d);
		chk(d, exp, $sformatf("read %h", idx));
	endtask : rchk

	// reset held 12 cycles with the given straps
	task automatic do_reset(input logic lv, input logic ob);
		reset <= 1'b1;
		lv_src <= lv;
		onboard <= ob;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask : do_reset

	// reset values; even index of a word pair answers both bytes
	task automatic t_reset_values;
		logic [15:0] idx [18] = '{16'hffb2, 16'hffb3, 16'hffb4, 16'hffb6, 16'hffbd, 16'hffbe,
			16'hffc0, 16'hffc2, 16'hffc4, 16'hffe0, 16'hffe4, 16'hffe6, 16'hffe8, 16'hffea,
			16'hfff0, 16'hfff4, 16'hfff8, 16'hfffb};
		logic [31:0] exp [18] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
			32'h08, 32'h0, 32'hffff, 32'hdfff, 32'hffff, 32'hffff, 32'hcf, 32'h0c, 32'h10, 32'h0};
		for (int i = 0; i < 18; i++) begin
			rchk(idx[i], exp[i]);
		end
	endtask : t_reset_values

	// bit, byte and word kinds accepted; bit, byte and unknown kinds refused
	task automatic t_access_kinds;
		i_core.wr(16'hffb7, 32'ha5, STRB_BYTE);
		rchk(16'hffb7, 32'ha5);
		i_core.wr(16'hffb7, 32'h5a, 4'hf);
		rchk(16'hffb7, 32'ha5);
		i_core.wr(16'hffb6, 32'h0001_0003, STRB_BIT);
		rchk(16'hffb6, 32'h08);
		chk({24'h0, sfr_bytes[SLOT_T1_MODE]}, 32'h08, "timer byte output");
		i_core.wr(16'hffe0, 32'h1234, STRB_WORD);
		i_core.wr(16'hffe1, 32'h0000_0004, STRB_BIT);
		rchk(16'hffe0, 32'h0234);
		rchk(16'hffe1, 32'h02);
		i_core.wr(16'hffb4, 32'hbeef, STRB_WORD);
		i_core.wr(16'hffb2, 32'h55, STRB_BYTE);
		rchk(16'hffb4, 32'hbeef);
		rchk(16'hffb2, 32'h0);
		i_core.wr(16'hffbf, 32'h0001_0000, STRB_BIT);
		rchk(16'hffbf, 32'h0);
		i_core.wr(16'hffbf, 32'h3c, STRB_BYTE);
		rchk(16'hffbf, 32'h3c);
		i_core.wr(16'hfff0, 32'h0, STRB_BIT);
		rchk(16'hfff0, 32'hcf);
		i_core.wr(16'hfff0, 32'hc8, STRB_BYTE);
		rchk(16'hfff0, 32'hc8);
		i_core.wr(16'hfff8, 32'h4, STRB_BIT);
		rchk(16'hfff8, 32'h0);
		i_core.wr(16'hfffb, 32'h07, STRB_BYTE);
		rchk(16'hfffb, 32'h07);
		i_core.wr(16'hffea, 32'h00aa, STRB_WORD);
		i_core.wr(16'hffe6, 32'h0, STRB_WORD);
		rchk(16'hffea, 32'h00aa);
		rchk(16'hffe6, 32'h0);
		// software moves expansion ram to its working size first
		i_core.wr(16'hfff4, 32'h0a, STRB_BYTE);
		rchk(16'hfff4, 32'h0a);
		i_core.wr(16'hffc2, 32'h81, STRB_BYTE);
		rchk(16'hffc2, 32'h81);
		i_core.wr(16'hffc0, 32'h5a, STRB_BYTE);
		// the counter takes the pulse at the very edge the write returns on
		@(posedge clk);
		chk(strobes, 1, "command pulses");
		chk({24'h0, cmd_data}, 32'h5a, "command byte");
		rchk(16'hffc0, 32'h0);
		i_core.wr(16'hffd8, 32'h77, STRB_BYTE);
		rchk(16'hffd8, 32'h0);
	endtask : t_access_kinds

	// status sticky, enable masks the line, clear drops it
	task automatic t_events;
		chk({31'h0, irq}, 32'h0, "irq masked");
		rchk(IDX_EVT_STATUS, 32'h07);
		i_core.wr(IDX_EVT_ENABLE, 32'h02, STRB_BYTE);
		chk({31'h0, irq}, 32'h1, "irq enabled");
		i_core.wr(IDX_EVT_CLEAR, 32'h02, STRB_BYTE);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rchk(IDX_EVT_STATUS, 32'h05);
		rchk(16'hffd9, 32'h0);
		chk({31'h0, irq}, 32'h1, "irq on unmapped read");
		i_core.wr(IDX_EVT_STATUS, 32'h00, STRB_BYTE);
		rchk(IDX_EVT_STATUS, 32'h07);
		i_core.wr(IDX_EVT_CLEAR, 32'h07, STRB_BYTE);
		rchk(IDX_EVT_STATUS, 32'h0);
	endtask : t_events

	// reset source and operating mode straps
	task automatic t_reset_source;
		i_core.wr(16'hffbe, 32'h44, STRB_BYTE);
		do_reset(1'b1, 1'b1);
		rchk(16'hffbe, 32'h44);
		rchk(16'hffbf, 32'h3c);
		rchk(16'hffc4, 32'h0c);
		do_reset(1'b0, 1'b0);
		rchk(16'hffbe, 32'h0);
		rchk(16'hffc4, 32'h08);
		rchk(16'hfff4, 32'h0c);
	endtask : t_reset_source

	// main sequence
	initial begin
		do_reset(1'b0, 1'b0);
		t_reset_values();
		t_access_kinds();
		t_events();
		t_reset_source();
		end_of_test();
	end
	// watchdog: about 70 accesses of a few cycles each fit well inside this span
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
endmodule : upper_sfr_register_map_tb_top
